// ==== shared/dti_cfg.svh ====
// register map, field positions, reset values and clock counts of the transfer unit
`ifndef DTI_CFG_SVH
`define DTI_CFG_SVH
`define DTI_OFF_CTRL 8'h00
`define DTI_OFF_STATUS 8'h04
`define DTI_OFF_INSTR0 8'h08
`define DTI_OFF_INSTR1 8'h0C
`define DTI_OFF_FLAGS 8'h10
`define DTI_OFF_CYCLES 8'h14
`define DTI_GPR_BLK 3'h1
`define DTI_SEG_BLK 4'h4
`define DTI_CTRL_START 0
`define DTI_CTRL_NARROW 1
`define DTI_STS_BUSY 0
`define DTI_STS_DONE 1
`define DTI_STS_ILLEGAL 2
`define DTI_STS_HOLD 3
`define DTI_FLG_S 7
`define DTI_FLG_Z 6
`define DTI_FLG_AC 4
`define DTI_FLG_P 2
`define DTI_FLG_CY 0
`define DTI_SEG_EXTRA 2'h0
`define DTI_SEG_PROG 2'h1
`define DTI_SEG_STACK 2'h2
`define DTI_SEG_PRIM 2'h3
`define DTI_R_ACC 3'h0
`define DTI_R_BASE 3'h3
`define DTI_R_BP 3'h5
`define DTI_R_SI 3'h6
`define DTI_R_DI 3'h7
`define DTI_RST_FLAGS 16'h0000
`define DTI_CLK_2 8'h02
`define DTI_CLK_3 8'h03
`define DTI_CLK_4 8'h04
`define DTI_CLK_9 8'h09
`define DTI_CLK_10 8'h0A
`define DTI_CLK_11 8'h0B
`define DTI_CLK_13 8'h0D
`define DTI_CLK_14 8'h0E
`define DTI_CLK_15 8'h0F
`define DTI_CLK_18 8'h12
`define DTI_CLK_26 8'h1A
`define DTI_CLK_ILL 8'h01
`endif

// ==== shared/dti_pkg.sv ====
// types of the data transfer instruction unit
package dti_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_MEM = 4'b0100,
    ST_WAIT = 4'b1000
  } dti_fsm_type;
  typedef enum logic [4:0] {
    K_RR = 5'h00, K_ST = 5'h01, K_LD = 5'h02, K_STI = 5'h03,
    K_RI = 5'h04, K_ALD = 5'h05, K_AST = 5'h06, K_SRR = 5'h07,
    K_SLD = 5'h08, K_RS = 5'h09, K_SST = 5'h0A, K_PTR = 5'h0B,
    K_AHF = 5'h0C, K_FAH = 5'h0D, K_LEA = 5'h0E, K_XLT = 5'h0F,
    K_XCH = 5'h10, K_ILL = 5'h1F
  } dti_kind_type;
  typedef logic [7:0][15:0] dti_gpr_type;
  typedef logic [3:0][15:0] dti_seg_type;
  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dti_mem_req_type;
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } dti_mem_rsp_type;
  typedef struct packed {
    dti_fsm_type st;
    logic [7:0] cyc;
    logic [7:0] last_cyc;
    logic phase;
    logic [47:0] instr;
    dti_gpr_type gpr;
    dti_seg_type seg;
    logic [15:0] flags;
    logic narrow;
    logic done;
    logic illegal;
    logic hold;
    dti_mem_req_type mem;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dti_state_type;
endpackage

// ==== testbench/dti_mem_model.sv ====
// behavioural memory on the far side of the transfer unit's memory port
`timescale 1ns/1ps
module dti_mem_model (
  input logic core_clk,
  input logic reset,
  input dti_pkg::dti_mem_req_type mem_req,
  output dti_pkg::dti_mem_rsp_type mem_rsp,
  input logic [3:0] lat
);
  logic [7:0] cells [0:255];
  logic [3:0] wait_cnt;
  logic [7:0] a;
  assign a = mem_req.addr[7:0];
  // known pattern so loads have a predictable answer; only 256 bytes, upper bits ignored
  initial begin
    for (int i = 0; i < 256; i++) cells[i] = 8'(i) ^ 8'h5A;
  end
  // one ack per request after lat idle cycles; read data churns between acks
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_cnt <= 4'h0;
      mem_rsp <= '0;
    end else if (mem_req.req && !mem_rsp.ack && wait_cnt >= lat) begin
      wait_cnt <= 4'h0;
      mem_rsp.ack <= 1'b1;
      mem_rsp.rdata <= {cells[a + 8'h01], cells[a]};
      if (mem_req.we) cells[a] <= mem_req.wdata[7:0];
      if (mem_req.we && mem_req.word) cells[a + 8'h01] <= mem_req.wdata[15:8];
    end else begin
      wait_cnt <= (mem_req.req && !mem_rsp.ack) ? wait_cnt + 4'h1 : 4'h0;
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
    end
  end
endmodule

// ==== testbench/dti_unit_assertions.sv ====
// port-level checks of the transfer unit, bound to its top module
`timescale 1ns/1ps
module dti_unit_assertions (
  input logic core_clk,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input dti_pkg::dti_mem_req_type mem_req,
  input dti_pkg::dti_mem_rsp_type mem_rsp,
  input logic irq_hold
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // register bus: one wait state, a single-cycle answer, errors only with it
  property p_pready_wait; $rose(penable) && psel |=> pready; endproperty
  a_pready_wait: assert property (p_pready_wait) else $error("bus answer late");
  property p_pready_pulse; pready |=> !pready; endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("bus answer too long");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside an answer");
  property p_err_addr; pready && (paddr[1:0] != 2'h0 || paddr[11:8] != 4'h0) |-> pslverr;
  endproperty
  a_err_addr: assert property (p_err_addr) else $error("bad address not refused");
  // memory port: a request stands unchanged until its acknowledge
  property p_req_hold; mem_req.req && !mem_rsp.ack |=> mem_req.req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_stable; mem_req.req && !mem_rsp.ack |=> $stable(mem_req.addr) &&
    $stable(mem_req.word); endproperty
  a_req_stable: assert property (p_req_stable) else $error("request moved");
  property p_req_store; mem_req.req && mem_req.we && !mem_rsp.ack |=> mem_req.we &&
    $stable(mem_req.wdata); endproperty
  a_req_store: assert property (p_req_store) else $error("store data moved");
  // after an ack only the pointer load goes on, two bytes further up
  property p_req_next; mem_req.req && mem_rsp.ack |=> !mem_req.req ||
    mem_req.addr == $past(mem_req.addr) + 20'h2; endproperty
  a_req_next: assert property (p_req_next) else $error("second transfer misplaced");
  cover property (mem_req.req && mem_req.we && mem_rsp.ack);
  cover property (pready && pslverr);
  cover property ($rose(irq_hold));
endmodule
bind dti_unit dti_unit_assertions chk (.core_clk(core_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .irq_hold(irq_hold));

// ==== testbench/dti_unit_bench.sv ====
// bench of the transfer unit: instruction table, then refusals and a second reset
`timescale 1ns/1ps
module dti_unit_bench;
  typedef struct packed {
    logic [47:0] ins;
    logic nar;
    logic [7:0] cyc;
    logic [7:0] adr;
    logic [15:0] val;
  } dti_row_type;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_hold, err;
  dti_pkg::dti_mem_req_type mem_req;
  dti_pkg::dti_mem_rsp_type mem_rsp;
  logic [3:0] lat = 4'h0;
  int mismatches = 0;
  int n_compared = 0;
  int ticks = 0;
  dti_row_type rows [0:33];
  logic [15:0] gpr_init [0:7] = '{16'h1234, 16'h5678, 16'h9ABC, 16'h0040, 16'h0010,
    16'h0000, 16'h0021, 16'h0030};
  always #2.5 core_clk = ~core_clk;
  dti_unit dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .irq_hold(irq_hold));
  dti_mem_model mem (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .lat(lat));
  // hang guard at 20000 cycles, over ten times the roughly 1200 cycles the run needs
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one register bus transfer; request held until the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // load, start, poll busy, then compare clocks, one register and the hold flag
  task automatic run(input dti_row_type r);
    apb(1'b1, 12'h008, r.ins[31:0]);
    apb(1'b1, 12'h00C, {16'h0000, r.ins[47:32]});
    apb(1'b1, 12'h000, {30'h0, r.nar, 1'b1});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, 12'h004, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    if (r.cyc != 8'h00) check(rd, {24'h0, r.cyc});
    if (r.adr != 8'h00) begin
      apb(1'b0, {4'h0, r.adr}, 32'h0);
      check(rd, {16'h0, r.val});
      check({31'h0, irq_hold}, {31'h0, r.ins[7:0] == 8'h8E});
    end
  endtask
  initial begin
    rows = '{
      '{48'hCA89,1'h0,8'h02,8'h28,16'h5678}, '{48'h148B,1'h0,8'h0F,8'h28,16'h787B},
      '{48'h058B,1'h1,8'h0F,8'h20,16'h6B6A}, '{48'h248A,1'h0,8'h0B,8'h20,16'h7B6A},
      '{48'hBEEFB9,1'h0,8'h04,8'h24,16'hBEEF}, '{48'h41A1,1'h0,8'h0E,8'h20,16'h181B},
      '{48'h50A3,1'h0,8'h09,8'h20,16'h181B}, '{48'h50168B,1'h0,8'h0B,8'h28,16'h181B},
      '{48'h61A2,1'h0,8'h09,8'h20,16'h181B}, '{48'h610E8A,1'h0,8'h0B,8'h24,16'hBE1B},
      '{48'h4321007006C7,1'h0,8'h0B,8'h24,16'hBE1B}, '{48'h702E8B,1'h0,8'h0B,8'h34,16'h4321},
      '{48'h2D89,1'h0,8'h09,8'h34,16'h4321}, '{48'h2D89,1'h1,8'h0D,8'h34,16'h4321},
      '{48'h258B,1'h0,8'h0B,8'h30,16'h4321}, '{48'h2488,1'h0,8'h09,8'h20,16'h181B},
      '{48'h2C8A,1'h0,8'h0B,8'h24,16'h181B}, '{48'hC38E,1'h0,8'h02,8'h40,16'h0040},
      '{48'hC68C,1'h0,8'h02,8'h38,16'h0040}, '{48'h057F8D,1'h0,8'h04,8'h3C,16'h0045},
      '{48'hD7,1'h0,8'h09,8'h20,16'h1801}, '{48'hCB87,1'h0,8'h03,8'h24,16'h0040},
      '{48'hC486,1'h0,8'h03,8'h20,16'h0118}, '{48'h9F,1'h0,8'h02,8'h20,16'hD518},
      '{48'h41B4,1'h0,8'h04,8'h10,16'h00D5}, '{48'h9E,1'h0,8'h03,8'h10,16'h0041},
      '{48'hA0168E,1'h0,8'h0B,8'h48,16'hFBFA}, '{48'hB1168C,1'h0,8'h0E,8'h48,16'hFBFA},
      '{48'hB2168C,1'h0,8'h0A,8'h48,16'hFBFA}, '{48'h8036C4,1'h0,8'h12,8'h40,16'hD9D8},
      '{48'h9116C5,1'h0,8'h1A,8'h4C,16'hCEC9}, '{48'h50168B,1'h0,8'h0B,8'h28,16'hBBBA},
      '{48'h0EC6,1'h0,8'h00,8'h00,16'h0000}, '{48'hC88E,1'h0,8'h00,8'h00,16'h0000}};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) apb(1'b1, 12'h020 + 12'(4 * i), {16'h0000, gpr_init[i]});
    apb(1'b1, 12'h010, 32'h000000D5);
    for (int i = 0; i < 31; i++) run(rows[i]);
    // slow memory, after the primary segment moved the address up by its shift
    lat <= 4'h6;
    run(rows[31]);
    lat <= 4'h0;
    // nonzero field of an immediate store is refused as illegal
    run(rows[32]);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, rd[2]}, 32'h1);
    // the program segment cannot be loaded
    run(rows[33]);
    apb(1'b0, 12'h044, 32'h0);
    check(rd, 32'h0);
    // unmapped and misaligned addresses are refused
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, 12'h102, 32'h0);
    check({31'h0, err}, 32'h1);
    // second reset clears segments, flags and the hold
    reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h04C, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq_hold}, 32'h0);
    stop_test();
  end
endmodule

// ==== verilog/dti_unit.sv ====
// data transfer instruction unit: decode, execute, memory transfer and apb register file
// Function
// [RQ1] segment selector 00 extra 01 program 10 stack 11 primary
// [RQ2] register to register copy, 2 clocks
// [RQ3] register store: 9 byte, 13 or 9 word
// [RQ4] memory load to register: 11 byte, 15 or 11
// [RQ5] immediate store needs reg field zero, 11/15
// [RQ6] immediate to register from opcode, 4 clocks
// [RQ7] direct accumulator load, 10 byte, 14 word
// [RQ8] direct accumulator store, 9 byte, 13/9 word
// [RQ9] segment from register except program; holds interrupts
// [RQ10] segment from memory word holds interrupts; 15/11
// [RQ11] segment to general register, 2 clocks
// [RQ12] segment store to memory, 14 or 10
// [RQ13] pointer load into primary segment, 26/18
// [RQ14] pointer load into extra segment, 26/18
// [RQ15] flags to high accumulator byte, 2 clocks
// [RQ16] high accumulator byte to flags, 3 clocks
// [RQ17] offset load writes address, 4 clocks
// [RQ18] table lookup byte at base plus low, 9
// [RQ19] register exchange, 3 clocks
// [RQ20] word bit one word, zero byte
// [RQ21] register field names byte or word registers
// [RQ22] memory operand from kind, location, displacement
// [RQ23] flags untouched except flag load
`timescale 1ns/1ps
`include "dti_cfg.svh"

module dti_unit (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dti_pkg::dti_mem_req_type mem_req,
  input dti_pkg::dti_mem_rsp_type mem_rsp,
  output logic irq_hold
);

  dti_pkg::dti_state_type state_ff;
  dti_pkg::dti_state_type nxt_state;

  // byte registers live in the low four words
  function automatic logic [15:0] rd_reg(input dti_pkg::dti_gpr_type g,
                                         input logic [2:0] n, input logic w);
    logic [15:0] v;
    v = g[{1'b0, n[1:0]}];
    if (w) begin
      rd_reg = g[n];
    end else if (n[2]) begin
      rd_reg = {8'h00, v[15:8]};
    end else begin
      rd_reg = {8'h00, v[7:0]};
    end
  endfunction

  // byte writes keep the other half of the word
  function automatic dti_pkg::dti_gpr_type wr_reg(input dti_pkg::dti_gpr_type g,
                                                  input logic [2:0] n, input logic w,
                                                  input logic [15:0] v);
    wr_reg = g;
    if (w) begin
      wr_reg[n] = v;
    end else if (n[2]) begin
      wr_reg[{1'b0, n[1:0]}][15:8] = v[7:0];
    end else begin
      wr_reg[{1'b0, n[1:0]}][7:0] = v[7:0];
    end
  endfunction

  // opcode classes; unknown or malformed encodings fall to illegal
  function automatic dti_pkg::dti_kind_type kind_of(input logic [7:0] op,
                                                    input logic [7:0] mr);
    logic rg;
    rg = (mr[7:6] == 2'h3);
    kind_of = dti_pkg::K_ILL;
    casez (op)
      8'b1000_100?: kind_of = rg ? dti_pkg::K_RR : dti_pkg::K_ST;
      8'b1000_101?: kind_of = rg ? dti_pkg::K_RR : dti_pkg::K_LD;
      8'b1100_011?: begin
        if (mr[5:3] == 3'h0 && !rg) begin
          kind_of = dti_pkg::K_STI; // RQ5
        end
      end
      8'b1011_????: kind_of = dti_pkg::K_RI;
      8'b1010_000?: kind_of = dti_pkg::K_ALD;
      8'b1010_001?: kind_of = dti_pkg::K_AST;
      8'h8E: begin
        if (!mr[5] && mr[4:3] != `DTI_SEG_PROG) begin
          kind_of = rg ? dti_pkg::K_SRR : dti_pkg::K_SLD; // RQ9 RQ10
        end
      end
      8'h8C: begin
        if (!mr[5]) begin
          kind_of = rg ? dti_pkg::K_RS : dti_pkg::K_SST;
        end
      end
      8'b1100_010?: kind_of = rg ? dti_pkg::K_ILL : dti_pkg::K_PTR;
      8'h9F: kind_of = dti_pkg::K_AHF;
      8'h9E: kind_of = dti_pkg::K_FAH;
      8'h8D: kind_of = rg ? dti_pkg::K_ILL : dti_pkg::K_LEA;
      8'hD7: kind_of = dti_pkg::K_XLT;
      8'b1000_011?: kind_of = rg ? dti_pkg::K_XCH : dti_pkg::K_ILL; // memory form refused
      default: kind_of = dti_pkg::K_ILL;
    endcase
  endfunction

  // processor clocks per instruction; slow means narrow bus or odd word
  function automatic logic [7:0] need_of(input dti_pkg::dti_kind_type k,
                                         input logic w, input logic slow);
    case (k)
      dti_pkg::K_RR: need_of = `DTI_CLK_2; // RQ2
      dti_pkg::K_SRR: need_of = `DTI_CLK_2; // RQ9
      dti_pkg::K_RS: need_of = `DTI_CLK_2; // RQ11
      dti_pkg::K_AHF: need_of = `DTI_CLK_2; // RQ15
      dti_pkg::K_ST: need_of = (w && slow) ? `DTI_CLK_13 : `DTI_CLK_9; // RQ3
      dti_pkg::K_AST: need_of = (w && slow) ? `DTI_CLK_13 : `DTI_CLK_9; // RQ8
      dti_pkg::K_LD: need_of = (w && slow) ? `DTI_CLK_15 : `DTI_CLK_11; // RQ4
      dti_pkg::K_STI: need_of = (w && slow) ? `DTI_CLK_15 : `DTI_CLK_11; // RQ5
      dti_pkg::K_SLD: need_of = slow ? `DTI_CLK_15 : `DTI_CLK_11; // RQ10
      dti_pkg::K_RI: need_of = `DTI_CLK_4; // RQ6
      dti_pkg::K_LEA: need_of = `DTI_CLK_4; // RQ17
      dti_pkg::K_ALD: need_of = w ? `DTI_CLK_14 : `DTI_CLK_10; // RQ7
      dti_pkg::K_SST: need_of = slow ? `DTI_CLK_14 : `DTI_CLK_10; // RQ12
      dti_pkg::K_PTR: need_of = slow ? `DTI_CLK_26 : `DTI_CLK_18; // RQ13 RQ14
      dti_pkg::K_FAH: need_of = `DTI_CLK_3; // RQ16
      dti_pkg::K_XCH: need_of = `DTI_CLK_3; // RQ19
      dti_pkg::K_XLT: need_of = `DTI_CLK_9; // RQ18
      default: need_of = `DTI_CLK_ILL;
    endcase
  endfunction

  // instruction fields
  logic [7:0] b0, b1, b2, b3;
  logic [1:0] md;
  logic [2:0] rf, rm;
  logic w;
  assign b0 = state_ff.instr[7:0];
  assign b1 = state_ff.instr[15:8];
  assign b2 = state_ff.instr[23:16];
  assign b3 = state_ff.instr[31:24];
  assign md = b1[7:6];
  assign rf = b1[5:3];
  assign rm = b1[2:0];
  assign w = b0[0]; // RQ20

  // effective address: base, index and displacement
  logic direct;
  logic [1:0] dlen;
  logic [15:0] disp, basea, indx, ea;
  logic [15:0] r_bw, r_bp;
  assign r_bw = state_ff.gpr[`DTI_R_BASE];
  assign r_bp = state_ff.gpr[`DTI_R_BP];
  assign direct = (md == 2'h0) && (rm == 3'h6);
  assign dlen = (md == 2'h1) ? 2'h1 : ((md == 2'h2 || direct) ? 2'h2 : 2'h0);
  assign disp = (md == 2'h1) ? {{8{b2[7]}}, b2} : // RQ22
                ((dlen == 2'h2) ? {b3, b2} : 16'h0000);
  assign basea = rm[2] ? (rm[1] ? (rm[0] ? r_bw : (direct ? 16'h0000 : r_bp)) : 16'h0000)
                       : (rm[1] ? r_bp : r_bw); // RQ22
  assign indx = (rm[2] && rm[1]) ? 16'h0000 :
                (rm[0] ? state_ff.gpr[`DTI_R_DI] : state_ff.gpr[`DTI_R_SI]);
  assign ea = basea + indx + disp;

  // bp based forms default to the stack segment
  logic stack_rel;
  assign stack_rel = (rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6 && !direct);

  dti_pkg::dti_kind_type kind;
  assign kind = kind_of(b0, b1);

  // memory side selection per class
  logic [1:0] msel;
  logic [15:0] moff, imm_m, mwd;
  logic [19:0] phys, phys_hi;
  logic mwe, mword, memk, slow;
  logic [7:0] need;
  always_comb begin
    msel = stack_rel ? `DTI_SEG_STACK : `DTI_SEG_PRIM; // RQ1
    moff = ea;
    if (kind == dti_pkg::K_ALD || kind == dti_pkg::K_AST) begin
      msel = `DTI_SEG_PRIM;
      moff = {b2, b1}; // RQ7 RQ8
    end else if (kind == dti_pkg::K_XLT) begin
      msel = `DTI_SEG_PRIM;
      moff = r_bw + {8'h00, state_ff.gpr[`DTI_R_ACC][7:0]}; // RQ18
    end
  end
  assign phys = {state_ff.seg[msel], 4'h0} + {4'h0, moff};
  assign phys_hi = {state_ff.seg[msel], 4'h0} + {4'h0, moff + 16'h0002}; // RQ13
  assign imm_m = 16'(state_ff.instr >> ({dlen, 3'b000} + 6'd16));
  assign memk = kind inside {dti_pkg::K_ST, dti_pkg::K_LD, dti_pkg::K_STI,
                             dti_pkg::K_ALD, dti_pkg::K_AST, dti_pkg::K_SLD,
                             dti_pkg::K_SST, dti_pkg::K_PTR, dti_pkg::K_XLT};
  assign mwe = kind inside {dti_pkg::K_ST, dti_pkg::K_STI, dti_pkg::K_AST, dti_pkg::K_SST};
  assign mword = (kind inside {dti_pkg::K_SLD, dti_pkg::K_SST, dti_pkg::K_PTR}) ? 1'b1 :
                 ((kind == dti_pkg::K_XLT) ? 1'b0 : w);
  assign mwd = (kind == dti_pkg::K_STI) ? imm_m :
               (kind == dti_pkg::K_AST) ? state_ff.gpr[`DTI_R_ACC] :
               (kind == dti_pkg::K_SST) ? state_ff.seg[rf[1:0]] :
               rd_reg(state_ff.gpr, rf, w); // RQ3
  // odd words and the narrow bus pay the extra cycles
  assign slow = state_ff.narrow | moff[0];
  assign need = need_of(kind, w, slow);

  logic busy;
  logic hit;
  logic [31:0] rd_val;
  logic [1:0] pseg;
  assign busy = (state_ff.st != dti_pkg::ST_IDLE);
  assign pseg = b0[0] ? `DTI_SEG_PRIM : `DTI_SEG_EXTRA; // RQ13 RQ14

  always_comb begin
    nxt_state = state_ff;
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    // read mux and address decode
    if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr[7:5] == `DTI_GPR_BLK) begin
      rd_val = {16'h0000, state_ff.gpr[paddr[4:2]]};
    end else if (paddr[7:4] == `DTI_SEG_BLK) begin
      rd_val = {16'h0000, state_ff.seg[paddr[3:2]]};
    end else begin
      case (paddr[7:0])
        `DTI_OFF_CTRL: rd_val[`DTI_CTRL_NARROW] = state_ff.narrow;
        `DTI_OFF_STATUS: begin
          rd_val[`DTI_STS_BUSY] = busy;
          rd_val[`DTI_STS_DONE] = state_ff.done;
          rd_val[`DTI_STS_ILLEGAL] = state_ff.illegal;
          rd_val[`DTI_STS_HOLD] = state_ff.hold;
        end
        `DTI_OFF_INSTR0: rd_val = state_ff.instr[31:0];
        `DTI_OFF_INSTR1: rd_val = {16'h0000, state_ff.instr[47:32]};
        `DTI_OFF_FLAGS: rd_val = {16'h0000, state_ff.flags};
        `DTI_OFF_CYCLES: rd_val = {24'h00_0000, state_ff.last_cyc};
        default: hit = 1'b0;
      endcase
    end
    // one wait state: pready rises in the second access cycle, one clock after penable
    nxt_state.pready = psel && penable && !state_ff.pready;
    // the error flag stands only beside pready, never into the next transfer
    nxt_state.pslverr = psel && penable && !state_ff.pready && !hit;
    if (psel && penable && !state_ff.pready) begin
      nxt_state.prdata = rd_val;
    end
    // writes land on the completing edge; most are ignored while busy
    if (psel && penable && pwrite && state_ff.pready && hit) begin
      if (paddr[7:0] == `DTI_OFF_STATUS) begin
        if (pwdata[`DTI_STS_DONE]) begin
          nxt_state.done = 1'b0;
        end
        if (pwdata[`DTI_STS_ILLEGAL]) begin
          nxt_state.illegal = 1'b0;
        end
      end else if (!busy) begin
        if (paddr[7:5] == `DTI_GPR_BLK) begin
          nxt_state.gpr[paddr[4:2]] = pwdata[15:0];
        end else if (paddr[7:4] == `DTI_SEG_BLK) begin
          nxt_state.seg[paddr[3:2]] = pwdata[15:0];
        end else begin
          case (paddr[7:0])
            `DTI_OFF_CTRL: begin
              nxt_state.narrow = pwdata[`DTI_CTRL_NARROW];
              if (pwdata[`DTI_CTRL_START]) begin
                nxt_state.st = dti_pkg::ST_EXEC;
                nxt_state.cyc = 8'h00;
                nxt_state.phase = 1'b0;
              end
            end
            `DTI_OFF_INSTR0: nxt_state.instr[31:0] = pwdata;
            `DTI_OFF_INSTR1: nxt_state.instr[47:32] = pwdata[15:0];
            `DTI_OFF_FLAGS: nxt_state.flags = pwdata[15:0];
            default: nxt_state.flags = nxt_state.flags;
          endcase
        end
      end
    end
    // elapsed clocks; saturate so a stuck memory cannot wrap the count
    if (busy && state_ff.cyc != 8'hFF) begin
      nxt_state.cyc = state_ff.cyc + 8'h01;
    end
    unique case (state_ff.st)
      dti_pkg::ST_IDLE: begin
        nxt_state.mem.req = 1'b0;
      end
      dti_pkg::ST_EXEC: begin
        nxt_state.st = dti_pkg::ST_WAIT;
        if (kind == dti_pkg::K_ILL) begin
          nxt_state.illegal = 1'b1;
        end else if (memk) begin
          nxt_state.st = dti_pkg::ST_MEM;
          nxt_state.mem.req = 1'b1;
          nxt_state.mem.we = mwe;
          nxt_state.mem.word = mword; // RQ20
          nxt_state.mem.addr = phys; // RQ22
          nxt_state.mem.wdata = mwd;
        end else begin
          // register only classes finish their writes here
          case (kind)
            dti_pkg::K_RR: begin
              if (b0[1]) begin
                nxt_state.gpr = wr_reg(state_ff.gpr, rf, w, rd_reg(state_ff.gpr, rm, w)); // RQ2
              end else begin
                nxt_state.gpr = wr_reg(state_ff.gpr, rm, w, rd_reg(state_ff.gpr, rf, w)); // RQ2
              end
            end
            dti_pkg::K_RI: nxt_state.gpr = wr_reg(state_ff.gpr, b0[2:0], b0[3], {b2, b1}); // RQ6 RQ21
            dti_pkg::K_SRR: nxt_state.seg[rf[1:0]] = state_ff.gpr[rm]; // RQ9
            dti_pkg::K_RS: nxt_state.gpr[rm] = state_ff.seg[rf[1:0]]; // RQ11
            dti_pkg::K_AHF: nxt_state.gpr[`DTI_R_ACC][15:8] = state_ff.flags[7:0]; // RQ15
            dti_pkg::K_FAH: begin
              // only the five documented flag bits move
              nxt_state.flags[`DTI_FLG_S] = state_ff.gpr[`DTI_R_ACC][8 + `DTI_FLG_S]; // RQ16
              nxt_state.flags[`DTI_FLG_Z] = state_ff.gpr[`DTI_R_ACC][8 + `DTI_FLG_Z];
              nxt_state.flags[`DTI_FLG_AC] = state_ff.gpr[`DTI_R_ACC][8 + `DTI_FLG_AC];
              nxt_state.flags[`DTI_FLG_P] = state_ff.gpr[`DTI_R_ACC][8 + `DTI_FLG_P];
              nxt_state.flags[`DTI_FLG_CY] = state_ff.gpr[`DTI_R_ACC][8 + `DTI_FLG_CY];
            end
            dti_pkg::K_LEA: nxt_state.gpr[rf] = ea; // RQ17
            dti_pkg::K_XCH: nxt_state.gpr = wr_reg(wr_reg(state_ff.gpr, rf, w,
                rd_reg(state_ff.gpr, rm, w)), rm, w, rd_reg(state_ff.gpr, rf, w)); // RQ19
            default: nxt_state.flags = state_ff.flags; // RQ23
          endcase
        end
      end
      dti_pkg::ST_MEM: begin
        if (mem_rsp.ack) begin
          case (kind)
            dti_pkg::K_LD: nxt_state.gpr = wr_reg(state_ff.gpr, rf, w, mem_rsp.rdata); // RQ4
            dti_pkg::K_ALD: begin
              nxt_state.gpr = wr_reg(state_ff.gpr, `DTI_R_ACC, w, mem_rsp.rdata); // RQ7
            end
            dti_pkg::K_SLD: nxt_state.seg[rf[1:0]] = mem_rsp.rdata; // RQ10
            dti_pkg::K_XLT: nxt_state.gpr[`DTI_R_ACC][7:0] = mem_rsp.rdata[7:0]; // RQ18
            dti_pkg::K_PTR: begin
              if (state_ff.phase) begin
                nxt_state.seg[pseg] = mem_rsp.rdata; // RQ14
              end else begin
                nxt_state.gpr[rf] = mem_rsp.rdata; // RQ13
              end
            end
            default: nxt_state.flags = state_ff.flags; // RQ23
          endcase
          if (kind == dti_pkg::K_PTR && !state_ff.phase) begin
            // second transfer fetches the segment word
            nxt_state.phase = 1'b1;
            nxt_state.mem.addr = phys_hi; // RQ13
          end else begin
            nxt_state.mem.req = 1'b0;
            nxt_state.st = dti_pkg::ST_WAIT;
          end
        end
      end
      dti_pkg::ST_WAIT: begin
        if (state_ff.cyc >= need - 8'h01) begin
          nxt_state.st = dti_pkg::ST_IDLE;
          nxt_state.done = 1'b1;
          nxt_state.last_cyc = state_ff.cyc + 8'h01;
          // interrupts stay off through the following instruction
          nxt_state.hold = (kind == dti_pkg::K_SRR) || (kind == dti_pkg::K_SLD); // RQ9 RQ10
        end
      end
      default: begin
        nxt_state.st = dti_pkg::ST_IDLE;
        nxt_state.mem.req = 1'b0;
      end
    endcase
  end

  // whole state in one register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.st <= dti_pkg::ST_IDLE;
      state_ff.flags <= `DTI_RST_FLAGS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign mem_req = state_ff.mem;
  assign irq_hold = state_ff.hold;

endmodule
